// ### include/clock_ref_pkg.sv
package clock_ref_pkg;

  // transport packet framing
  localparam logic [7:0] SYNC_BYTE = 8'h47;
  localparam logic [7:0] PKT_LAST = 8'hbb;
  localparam logic [1:0] AFC_PCR_ONLY = 2'h2;
  localparam logic [1:0] AFC_PCR_PAYLOAD = 2'h3;
  localparam logic [7:0] AF_LEN_PCR = 8'h07;
  localparam logic [7:0] AF_FLAGS_PCR = 8'h10;
  localparam logic [7:0] PTR_IMMEDIATE = 8'h00;

  // last byte index inside each multi-byte field
  localparam logic [2:0] HDR_LAST = 3'h2;
  localparam logic [2:0] PCR_LAST = 3'h5;
  localparam logic [2:0] SEC_HDR_LAST = 3'h7;
  localparam logic [2:0] ENTRY_LAST = 3'h5;
  localparam logic [2:0] CRC_LAST = 3'h3;

  // crc-32, msb first, no reflection
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'h00000000;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PID = 8'h04;
  localparam logic [7:0] REG_TAGS = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_PCR_LO = 8'h14;
  localparam logic [7:0] REG_PCR_HI = 8'h18;
  localparam logic [7:0] REG_CORR_LO = 8'h1c;
  localparam logic [7:0] REG_CORR_HI = 8'h20;
  localparam logic [7:0] REG_FWD = 8'h24;
  localparam logic [7:0] REG_RET = 8'h28;

  // field positions
  localparam int TAG_ORB_LSB = 0;
  localparam int TAG_CC_LSB = 8;
  localparam int TAG_HUB_LSB = 16;
  localparam int PCR_HI_EXT_LSB = 16;

  // status / mask bits
  localparam int EV_W = 4;
  localparam int EV_PCR = 0;
  localparam int EV_SEC_OK = 1;
  localparam int EV_CRC_ERR = 2;
  localparam int EV_MALFORMED = 3;

  // reset values
  localparam logic CTRL_RST = 1'h0;
  localparam logic [12:0] PID_RST = 13'h0000;
  localparam logic [7:0] TAG_RST = 8'h00;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  typedef enum logic [15:0] {
    S_IDLE  = 16'h0001,
    S_HDR   = 16'h0002,
    S_AFLEN = 16'h0004,
    S_AFFLG = 16'h0008,
    S_PCR   = 16'h0010,
    S_PTR   = 16'h0020,
    S_PSKIP = 16'h0040,
    S_SECH  = 16'h0080,
    S_FCNT  = 16'h0100,
    S_FENT  = 16'h0200,
    S_RCNT  = 16'h0400,
    S_RENT  = 16'h0800,
    S_DLEN  = 16'h1000,
    S_DESC  = 16'h2000,
    S_CRCB  = 16'h4000,
    S_CHECK = 16'h8000
  } state_e;

  // states whose bytes belong to the section and feed the crc
  localparam logic [15:0] CRC_STATES = 16'h7f80;
  // states that must not meet the end of the packet
  localparam logic [15:0] SECTION_STATES = 16'h7fe0;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic sop;
  } ts_in_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } reg_bus_s;

  typedef struct packed {
    logic [32:0] pcr_base;
    logic [8:0] pcr_ext;
    logic pcr_valid;
    logic [32:0] correction;
    logic corr_valid;
  } timing_out_s;

  typedef struct packed {
    logic [31:0] crc;
  } crc_st_s;

  typedef struct packed {
    state_e state;
    logic [7:0] bcnt;
    logic [7:0] cnt;
    logic [2:0] idx;
    logic pusi;
    logic [1:0] afc;
    logic [7:0] t1;
    logic [7:0] t2;
    logic [39:0] acc;
    logic fwd_hit;
    logic ret_hit;
    logic [31:0] fwd_d;
    logic [31:0] ret_d;
    logic enable;
    logic [12:0] pid;
    logic [7:0] orb_tag;
    logic [7:0] cc_tag;
    logic [7:0] hub_tag;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [31:0] fwd_applied;
    logic [31:0] ret_applied;
    logic [31:0] rdata;
    timing_out_s tout;
  } parser_st_s;

endpackage : clock_ref_pkg

// ### hw/crc32_engine.sv
`timescale 1ns/1ps
module crc32_engine (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_en,
  input wire logic [7:0] i_data,
  output logic [31:0] o_crc
);
  import clock_ref_pkg::*;

  crc_st_s st;
  crc_st_s next_st;

  always_comb begin
    logic [31:0] c;
    logic fb;
    c = st.crc;
    fb = 1'b0;
    next_st = st;
    for (int i = 7; i >= 0; i--) begin
      fb = c[31] ^ i_data[i];
      c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
    end
    // clear wins: the pointer byte that opens a section is never section data
    if (i_clear) begin
      next_st.crc = CRC_INIT;
    end else if (i_en) begin
      next_st.crc = c;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '{crc: CRC_INIT};
    end else begin
      st <= next_st;
    end
  end

  assign o_crc = st.crc;

endmodule : crc32_engine

// ### hw/clock_ref_ts_packet_codec.sv
// Behaviour
// RQ1 - a packet with the delay section has the start indicator set and its first payload byte is a pointer.
// RQ2 - the pointer counts the bytes skipped before the section, zero meaning the section follows at once.
// RQ3 - adaptation control 10 means clock reference only, 11 means adaptation field plus delay payload.
// RQ4 - the sender codes adaptation length 7 with only the clock reference flag set.
// RQ5 - the clock reference base and extension are taken from the adaptation field.
// RQ6 - the sender keeps the whole section inside the packet that carries the clock reference.
// RQ7 - after the 64-bit section header an 8-bit count gives forward entries of tag, tag and 32-bit delay.
// RQ8 - an 8-bit count then gives return entries of orbiter tag, hub tag and 32-bit delay.
// RQ9 - an 8-bit descriptor length follows and that many bytes are skipped before the crc.
// RQ10 - the section ends in a crc-32 that leaves a zero remainder over the whole section.
// RQ11 - each delay is a 32-bit count in clock reference units.
// RQ12 - each entry's tags are compared with the orbiter, control centre and hub tags in use.
// RQ13 - a matching forward entry advances the transmit instant by its delay.
// RQ14 - a matching return entry adds its delay to the position-based delay.
// RQ15 - with both matches the correction is the sum of the two delays.
// RQ16 - with no match or zero delays the correction is zero.
// RQ17 - a section with a bad crc is dropped, the old correction kept and an error flagged.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module clock_ref_ts_packet_codec (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire clock_ref_pkg::ts_in_s i_ts,
  input wire clock_ref_pkg::reg_bus_s i_bus,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output clock_ref_pkg::timing_out_s o_timing
);
  import clock_ref_pkg::*;

  parser_st_s st;
  parser_st_s next_st;
  logic [31:0] crc;
  logic crc_clear;
  logic crc_en;
  logic [31:0] h_delay;
  logic [8:0] h_ext;
  logic [32:0] h_base;
  logic h_fwd_match;
  logic h_ret_match;
  logic [32:0] fwd_part;
  logic [32:0] ret_part;

  crc32_engine u_crc (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_clear(crc_clear),
    .i_en(crc_en),
    .i_data(i_ts.data),
    .o_crc(crc)
  );

  // a delay or clock reference completes on the byte now arriving
  assign h_delay = {st.acc[23:0], i_ts.data};
  assign h_base = st.acc[39:7];
  assign h_ext = {st.acc[0], i_ts.data};
  assign h_fwd_match = (st.t1 == st.orb_tag) && (st.t2 == st.cc_tag); // RQ12
  assign h_ret_match = (st.t1 == st.orb_tag) && (st.t2 == st.hub_tag); // RQ12
  assign fwd_part = st.fwd_hit ? {1'b0, st.fwd_d} : 33'h000000000; // RQ16
  assign ret_part = st.ret_hit ? {1'b0, st.ret_d} : 33'h000000000; // RQ16

  always_comb begin
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] w1c;
    logic last_byte;
    ev = '0;
    w1c = '0;
    last_byte = i_ts.valid && !i_ts.sop && (st.bcnt == PKT_LAST);
    next_st = st;
    next_st.tout.pcr_valid = 1'b0;
    next_st.tout.corr_valid = 1'b0;
    crc_clear = 1'b0;
    crc_en = i_ts.valid && ((st.state & CRC_STATES) != 16'h0000); // RQ10
    if (i_ts.valid) begin
      next_st.bcnt = st.bcnt + 8'h01;
    end

    case (st.state)
      S_IDLE: begin
      end
      S_HDR: if (i_ts.valid) begin
        next_st.idx = st.idx + 3'h1;
        if (st.idx == 3'h0) begin
          next_st.pusi = i_ts.data[6];
          next_st.t1 = {3'h0, i_ts.data[4:0]};
          if (i_ts.data[7]) begin
            next_st.state = S_IDLE;
          end
        end else if (st.idx == 3'h1) begin
          if (!st.enable || {st.t1[4:0], i_ts.data} != st.pid) begin
            next_st.state = S_IDLE;
          end
        end else begin
          next_st.afc = i_ts.data[5:4];
          // packets with no adaptation field cannot carry the clock reference
          if (i_ts.data[5:4] == AFC_PCR_ONLY || i_ts.data[5:4] == AFC_PCR_PAYLOAD) begin // RQ3
            next_st.state = S_AFLEN;
          end else begin
            next_st.state = S_IDLE;
          end
        end
      end
      S_AFLEN: if (i_ts.valid) begin
        next_st.state = (i_ts.data == AF_LEN_PCR) ? S_AFFLG : S_IDLE; // RQ4
        ev[EV_MALFORMED] = (i_ts.data != AF_LEN_PCR);
      end
      S_AFFLG: if (i_ts.valid) begin
        next_st.state = (i_ts.data == AF_FLAGS_PCR) ? S_PCR : S_IDLE; // RQ4
        ev[EV_MALFORMED] = (i_ts.data != AF_FLAGS_PCR);
        next_st.idx = 3'h0;
      end
      S_PCR: if (i_ts.valid) begin
        next_st.acc = {st.acc[31:0], i_ts.data};
        next_st.idx = st.idx + 3'h1;
        if (st.idx == PCR_LAST) begin
          next_st.tout.pcr_base = h_base; // RQ5
          next_st.tout.pcr_ext = h_ext; // RQ5
          next_st.tout.pcr_valid = 1'b1;
          ev[EV_PCR] = 1'b1;
          // a payload without the start indicator holds no section start
          next_st.state = (st.afc == AFC_PCR_PAYLOAD && st.pusi) ? S_PTR : S_IDLE; // RQ1
        end
      end
      S_PTR: if (i_ts.valid) begin
        next_st.cnt = i_ts.data;
        next_st.idx = 3'h0;
        next_st.fwd_hit = 1'b0;
        next_st.ret_hit = 1'b0;
        crc_clear = (i_ts.data == PTR_IMMEDIATE); // RQ2
        next_st.state = (i_ts.data == PTR_IMMEDIATE) ? S_SECH : S_PSKIP; // RQ2
      end
      S_PSKIP: if (i_ts.valid) begin
        next_st.cnt = st.cnt - 8'h01;
        if (st.cnt == 8'h01) begin
          crc_clear = 1'b1;
          next_st.state = S_SECH; // RQ2
        end
      end
      S_SECH: if (i_ts.valid) begin
        next_st.idx = st.idx + 3'h1;
        if (st.idx == SEC_HDR_LAST) begin
          next_st.state = S_FCNT; // RQ7
        end
      end
      S_FCNT, S_RCNT: if (i_ts.valid) begin
        next_st.cnt = i_ts.data;
        next_st.idx = 3'h0;
        if (i_ts.data != 8'h00) begin
          next_st.state = (st.state == S_FCNT) ? S_FENT : S_RENT; // RQ7 RQ8
        end else begin
          next_st.state = (st.state == S_FCNT) ? S_RCNT : S_DLEN; // RQ7 RQ8
        end
      end
      S_FENT, S_RENT: if (i_ts.valid) begin
        next_st.idx = st.idx + 3'h1;
        next_st.acc = {st.acc[31:0], i_ts.data};
        if (st.idx == 3'h0) begin
          next_st.t1 = i_ts.data;
        end
        if (st.idx == 3'h1) begin
          next_st.t2 = i_ts.data;
        end
        if (st.idx == ENTRY_LAST) begin
          next_st.idx = 3'h0;
          next_st.cnt = st.cnt - 8'h01;
          // the first matching entry of each kind is kept
          if (st.state == S_FENT && h_fwd_match && !st.fwd_hit) begin // RQ12
            next_st.fwd_hit = 1'b1;
            next_st.fwd_d = h_delay; // RQ11
          end
          if (st.state == S_RENT && h_ret_match && !st.ret_hit) begin // RQ12
            next_st.ret_hit = 1'b1;
            next_st.ret_d = h_delay; // RQ11
          end
          if (st.cnt == 8'h01) begin
            next_st.state = (st.state == S_FENT) ? S_RCNT : S_DLEN; // RQ8
          end
        end
      end
      S_DLEN: if (i_ts.valid) begin
        next_st.cnt = i_ts.data;
        next_st.idx = 3'h0;
        next_st.state = (i_ts.data == 8'h00) ? S_CRCB : S_DESC; // RQ9
      end
      S_DESC: if (i_ts.valid) begin
        next_st.cnt = st.cnt - 8'h01;
        if (st.cnt == 8'h01) begin
          next_st.state = S_CRCB; // RQ9
        end
      end
      S_CRCB: if (i_ts.valid) begin
        next_st.idx = st.idx + 3'h1;
        if (st.idx == CRC_LAST) begin
          next_st.state = S_CHECK;
        end
      end
      S_CHECK: begin
        // one cycle late so the engine has absorbed the last crc byte
        next_st.state = S_IDLE;
        if (crc == CRC_RESIDUE) begin // RQ10
          next_st.tout.correction = fwd_part + ret_part; // RQ13 RQ14 RQ15 RQ16
          next_st.tout.corr_valid = 1'b1;
          next_st.fwd_applied = fwd_part[31:0];
          next_st.ret_applied = ret_part[31:0];
          ev[EV_SEC_OK] = 1'b1;
        end else begin
          ev[EV_CRC_ERR] = 1'b1; // RQ17
        end
      end
      default: begin
        next_st.state = S_IDLE;
      end
    endcase

    // a section cut by the end of the packet is dropped whole
    if (last_byte && ((next_st.state & SECTION_STATES) != 16'h0000)) begin
      next_st.state = S_IDLE;
      ev[EV_MALFORMED] = 1'b1;
    end

    if (i_ts.valid && i_ts.sop) begin
      next_st.bcnt = 8'h01;
      next_st.idx = 3'h0;
      // a check in flight still latches its result at this same edge, so the next packet is not lost
      next_st.state = (i_ts.data == SYNC_BYTE) ? S_HDR : S_IDLE;
    end

    if (i_bus.we) begin
      case (i_bus.addr)
        REG_CTRL: next_st.enable = i_bus.wdata[0];
        REG_PID: next_st.pid = i_bus.wdata[12:0];
        REG_TAGS: begin
          next_st.orb_tag = i_bus.wdata[TAG_ORB_LSB +: 8];
          next_st.cc_tag = i_bus.wdata[TAG_CC_LSB +: 8];
          next_st.hub_tag = i_bus.wdata[TAG_HUB_LSB +: 8];
        end
        REG_STATUS: w1c = i_bus.wdata[EV_W-1:0];
        REG_MASK: next_st.mask = i_bus.wdata[EV_W-1:0];
        default: begin
        end
      endcase
    end
    // a new event in the cycle of its clear survives
    next_st.status = (st.status & ~w1c) | ev;

    next_st.rdata = 32'h00000000;
    if (i_bus.re) begin
      case (i_bus.addr)
        REG_CTRL: next_st.rdata = {31'h00000000, st.enable};
        REG_PID: next_st.rdata = {19'h00000, st.pid};
        REG_TAGS: next_st.rdata = {8'h00, st.hub_tag, st.cc_tag, st.orb_tag};
        REG_STATUS: next_st.rdata = {28'h0000000, st.status};
        REG_MASK: next_st.rdata = {28'h0000000, st.mask};
        REG_PCR_LO: next_st.rdata = st.tout.pcr_base[31:0];
        REG_PCR_HI: next_st.rdata = {7'h00, st.tout.pcr_ext, 15'h0000, st.tout.pcr_base[32]};
        REG_CORR_LO: next_st.rdata = st.tout.correction[31:0];
        REG_CORR_HI: next_st.rdata = {31'h00000000, st.tout.correction[32]};
        REG_FWD: next_st.rdata = st.fwd_applied;
        REG_RET: next_st.rdata = st.ret_applied;
        default: next_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= '0;
      st.state <= S_IDLE;
      st.enable <= CTRL_RST;
      st.pid <= PID_RST;
      st.orb_tag <= TAG_RST;
      st.cc_tag <= TAG_RST;
      st.hub_tag <= TAG_RST;
      st.mask <= MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_timing = st.tout;
  assign o_irq = |(st.status & st.mask);

  logic last_byte_w;
  assign last_byte_w = i_ts.valid && !i_ts.sop && (st.bcnt == PKT_LAST);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_check_ok;
    st.state == S_CHECK && crc == CRC_RESIDUE;
  endsequence

  sequence s_check_bad;
    st.state == S_CHECK && crc != CRC_RESIDUE;
  endsequence

  sequence s_pcr_done;
    st.state == S_PCR && i_ts.valid && st.idx == PCR_LAST;
  endsequence

  sequence s_fwd_entry_hit;
    st.state == S_FENT && i_ts.valid && !i_ts.sop && st.idx == ENTRY_LAST && h_fwd_match && !st.fwd_hit;
  endsequence

  a_pointer_gate: assert property ( // RQ1
    st.state == S_PTR |-> st.pusi && st.afc == AFC_PCR_PAYLOAD)
    else $error("pointer parsed without start indicator and payload");

  a_pointer_zero: assert property ( // RQ2
    st.state == S_PTR && i_ts.valid && !i_ts.sop && i_ts.data == PTR_IMMEDIATE && !last_byte_w
    |=> st.state == S_SECH && st.idx == 3'h0 && crc == CRC_INIT)
    else $error("zero pointer did not open the section");

  a_pcr_only: assert property ( // RQ3
    s_pcr_done ##0 (st.afc == AFC_PCR_ONLY) |=> st.state != S_PTR ##1 st.state != S_SECH)
    else $error("clock reference only packet entered a section");

  a_pcr_fields: assert property ( // RQ5
    s_pcr_done ##0 !i_ts.sop |=> o_timing.pcr_valid && o_timing.pcr_ext == $past(h_ext)
      && o_timing.pcr_base == $past(h_base))
    else $error("clock reference fields not published");

  a_fwd_capture: assert property ( // RQ12
    s_fwd_entry_hit |=> st.fwd_hit && st.fwd_d == $past(h_delay))
    else $error("matching forward entry not captured");

  a_desc_skip: assert property ( // RQ9
    st.state == S_DLEN && i_ts.valid && !i_ts.sop && i_ts.data == 8'h03 && !last_byte_w
    |=> st.state == S_DESC ##1 (st.state == S_DESC || !$past(i_ts.valid)))
    else $error("descriptor bytes not skipped");

  a_corr_sum: assert property ( // RQ15
    s_check_ok ##0 (st.fwd_hit && st.ret_hit)
    |=> o_timing.corr_valid && o_timing.correction == $past(fwd_part) + $past(ret_part))
    else $error("correction is not the sum of both delays");

  a_corr_fwd: assert property ( // RQ13
    s_check_ok ##0 (st.fwd_hit && !st.ret_hit) |=> o_timing.correction == {1'b0, $past(st.fwd_d)})
    else $error("forward delay not applied");

  a_corr_ret: assert property ( // RQ14
    s_check_ok ##0 (!st.fwd_hit && st.ret_hit) |=> o_timing.correction == {1'b0, $past(st.ret_d)})
    else $error("return delay not applied");

  a_corr_none: assert property ( // RQ16
    s_check_ok ##0 (!st.fwd_hit && !st.ret_hit) |=> o_timing.correction == 33'h000000000)
    else $error("correction not zero without a match");

  a_crc_reject: assert property ( // RQ17
    s_check_bad |=> !o_timing.corr_valid && $stable(o_timing.correction) && st.status[EV_CRC_ERR])
    else $error("bad crc section was applied or not flagged");

endmodule : clock_ref_ts_packet_codec

// ### verif/ts_mux_model.sv
`timescale 1ns/1ps
module ts_mux_model
  import clock_ref_pkg::*;
(
  input wire logic i_clk,
  output ts_in_s o_ts
);
  logic [7:0] sec[$];
  logic [7:0] pkt[$];

  initial o_ts = '0;

  // the crc is made here on its own so the parser is judged against an independent generator
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = (c[31] ^ b[i]) ? ({c[30:0], 1'b0} ^ CRC_POLY) : {c[30:0], 1'b0};
    end
    return c;
  endfunction : crc_step

  task automatic send(input logic [12:0] pid, input logic [1:0] afc, input logic [7:0] aflen,
                      input logic [41:0] pcr, input logic [7:0] ptr, input logic bad_crc);
    logic [47:0] pf;
    logic [31:0] crc;
    pf = {pcr[41:9], 6'h3f, pcr[8:0]};
    pkt.delete();
    pkt.push_back(SYNC_BYTE);
    pkt.push_back({1'b0, afc == AFC_PCR_PAYLOAD, 1'b0, pid[12:8]});
    pkt.push_back(pid[7:0]);
    pkt.push_back({2'b00, afc, 4'h0});
    pkt.push_back(aflen);
    pkt.push_back(AF_FLAGS_PCR);
    for (int i = 5; i >= 0; i--) pkt.push_back(pf[i*8 +: 8]);
    if (afc == AFC_PCR_PAYLOAD) begin
      pkt.push_back(ptr);
      repeat (ptr) pkt.push_back(8'hff);
      crc = CRC_INIT;
      foreach (sec[i]) begin
        pkt.push_back(sec[i]);
        crc = crc_step(crc, sec[i]);
      end
      if (bad_crc) crc = ~crc;
      for (int i = 3; i >= 0; i--) pkt.push_back(crc[i*8 +: 8]);
    end
    // stuffing keeps the whole section inside this one packet
    while (pkt.size() < 188) pkt.push_back(8'hff);
    foreach (pkt[i]) begin
      @(posedge i_clk);
      o_ts <= '{data: pkt[i], valid: 1'b1, sop: i == 0};
      if (i % 61 == 60) begin
        @(posedge i_clk);
        o_ts <= '{data: ~pkt[i], valid: 1'b0, sop: 1'b0};
      end
    end
    @(posedge i_clk);
    o_ts <= '{data: ~pkt[187], valid: 1'b0, sop: 1'b0};
  endtask : send
endmodule : ts_mux_model

// ### verif/test_clock_ref_ts_packet_codec.sv
`timescale 1ns/1ps
module test_clock_ref_ts_packet_codec;
  import clock_ref_pkg::*;
  logic i_clk;
  logic i_sys_rst;
  ts_in_s ts;
  reg_bus_s bus;
  logic [31:0] rdata;
  logic irq;
  timing_out_s tim;
  int num_errors;
  int num_checks;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] rq[$];
  logic [41:0] pq[$];
  logic [32:0] cq[$];
  logic rd_pend = 1'b0;
  logic [7:0] orb;
  logic [7:0] cc;
  logic [7:0] hub;
  logic [31:0] df;
  logic [31:0] dr;
  logic [31:0] ef;
  logic [31:0] er;
  logic [12:0] pid;
  logic [41:0] pcr;
  logic [32:0] corr;
  logic fm;
  logic rm;

  clock_ref_ts_packet_codec clock_ref_ts_packet_codec_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ts(ts),
    .i_bus(bus), .o_rdata(rdata), .o_irq(irq), .o_timing(tim));
  ts_mux_model ts_mux_model_inst (.i_clk(i_clk), .o_ts(ts));

  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge i_clk);
    bus.we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    rq.push_back(exp);
    bus <= '{addr: a, wdata: xs(), we: 1'b0, re: 1'b1};
    @(posedge i_clk);
    bus.re <= 1'b0;
  endtask : rd

  // watcher: every result that shows at the outputs takes the oldest note of its kind
  always @(posedge i_clk) begin
    rd_pend <= (bus.re === 1'b1);
    if (rd_pend) chk(rdata, rq.pop_front());
    if (tim.pcr_valid === 1'b1) begin
      if (pq.size() == 0) chk(1'b1, 1'b0);
      else chk({tim.pcr_base, tim.pcr_ext}, pq.pop_front());
    end
    if (tim.corr_valid === 1'b1) begin
      if (cq.size() == 0) chk(1'b1, 1'b0);
      else chk(tim.correction, cq.pop_front());
    end
  end

  task automatic settle();
    int n;
    n = 0;
    while ((pq.size() + cq.size() + rq.size()) != 0 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 400) begin
      num_errors++;
      end_of_test();
    end
  endtask : settle

  task automatic put(input logic [7:0] b);
    ts_mux_model_inst.sec.push_back(b);
  endtask : put

  task automatic entry(input logic [7:0] a, input logic [7:0] b, input logic [31:0] d);
    put(a);
    put(b);
    for (int i = 3; i >= 0; i--) put(d[i*8 +: 8]);
  endtask : entry

  task automatic packet(input logic [12:0] p, input logic [1:0] afc, input logic [7:0] aflen,
                        input logic [7:0] ptr, input logic bad, input logic exp_pcr, input logic exp_corr);
    r = xs();
    pcr = {r[9:0], xs()};
    if (exp_pcr) pq.push_back(pcr);
    if (exp_corr) cq.push_back(corr);
    ts_mux_model_inst.send(p, afc, aflen, pcr, ptr, bad);
    settle();
  endtask : packet

  initial begin
    repeat (100000) @(posedge i_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    i_sys_rst = 1'b1;
    bus = '0;
    seed = 32'h07b0;
    num_errors = 0;
    num_checks = 0;
    orb = 8'h11;
    cc = 8'h22;
    hub = 8'h33;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    // every register reads zero after reset, unmapped places too
    for (int a = 0; a <= 8'h2c; a += 4) rd(a[7:0], 32'h0);
    rd(8'hfc, 32'h0);
    r = xs();
    pid = r[12:0];
    wr(REG_CTRL, 32'h1);
    wr(REG_PID, {19'h0, pid});
    wr(REG_TAGS, {8'h0, hub, cc, orb});
    wr(REG_FWD, r);
    rd(REG_PID, {19'h0, pid});
    rd(REG_TAGS, {8'h0, hub, cc, orb});
    rd(REG_FWD, 32'h0);
    settle();
    $display("test registers done");

    corr = 33'h0;
    packet(pid, AFC_PCR_ONLY, AF_LEN_PCR, 8'h00, 1'b0, 1'b1, 1'b0);
    rd(REG_PCR_LO, pcr[40:9]);
    rd(REG_PCR_HI, {7'h0, pcr[8:0], 15'h0, pcr[41]});
    rd(REG_STATUS, 32'h1);
    settle();
    chk(irq, 1'b0);
    wr(REG_MASK, 32'h1);
    // the write lands at the edge the task returns on, so look once it has settled
    @(negedge i_clk);
    chk(irq, 1'b1);
    wr(REG_STATUS, 32'h1);
    @(negedge i_clk);
    chk(irq, 1'b0);
    $display("test clock reference only done");

    // k: 0 random match, 1 bad crc, 2 all-ones carry, 3 no match, 4 forward only, 5 return only
    wr(REG_MASK, 32'h4);
    ef = 32'h0;
    er = 32'h0;
    for (int k = 0; k < 6; k++) begin
      fm = (k != 3) && (k != 5);
      rm = (k != 3) && (k != 4);
      df = (k == 0 || k > 3) ? xs() : 32'hffffffff;
      dr = (k == 0 || k > 3) ? xs() : 32'hffffffff;
      ts_mux_model_inst.sec.delete();
      repeat (8) begin
        r = xs();
        put(r[7:0]);
      end
      put(8'h02);
      entry(orb, 8'h99, xs());
      entry(fm ? orb : 8'h12, cc, df);
      put(8'h02);
      entry(8'h55, hub, xs());
      entry(orb, rm ? hub : 8'h34, dr);
      put(8'h03);
      repeat (3) put(orb);
      if (k != 1) begin
        ef = fm ? df : 32'h0;
        er = rm ? dr : 32'h0;
        corr = {1'b0, ef} + {1'b0, er};
      end
      packet(pid, AFC_PCR_PAYLOAD, AF_LEN_PCR, {k[6:0], 1'b0}, k == 1, 1'b1, k != 1);
      chk(irq, k == 1);
      rd(REG_FWD, ef);
      rd(REG_RET, er);
      rd(REG_CORR_LO, corr[31:0]);
      rd(REG_CORR_HI, {31'h0, corr[32]});
      rd(REG_STATUS, k == 1 ? 32'h5 : 32'h3);
      wr(REG_STATUS, 32'hf);
      settle();
      $display("test section %0d done", k);
    end
    chk(irq, 1'b0);

    // refused packets: bad adaptation length, foreign pid, control code 01 with no adaptation field
    packet(pid, AFC_PCR_ONLY, 8'h08, 8'h00, 1'b0, 1'b0, 1'b0);
    rd(REG_STATUS, 32'h8);
    wr(REG_STATUS, 32'hf);
    packet(pid ^ 13'h1, AFC_PCR_ONLY, AF_LEN_PCR, 8'h00, 1'b0, 1'b0, 1'b0);
    packet(pid, 2'h1, AF_LEN_PCR, 8'h00, 1'b0, 1'b0, 1'b0);
    rd(REG_STATUS, 32'h0);
    settle();
    $display("test refusals done");
    end_of_test();
  end
endmodule : test_clock_ref_ts_packet_codec
